// ==== rdm_fault_queue.sv ====
// Fault queue for one limit comparison.
// Assumes i_sample pulses once per conversion end, same clock.
`timescale 1ns/1ps
`default_nettype none
module rdm_fault_queue import rdm_pkg::*; (
  input wire logic i_ref_clk, // System clock
  input wire logic i_sys_rst, // Async reset, high
  input wire logic i_sample,  // Conversion end pulse
  input wire logic i_out,     // Reading out of limit
  input wire logic i_qen,     // Queue enabled
  output logic o_trip         // Qualified alarm pulse
);
  logic [1:0] run; // Consecutive out-of-limit count

  // ------------------------------------------------------------
  // Run counter
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run <= 2'h0;
    end else if (i_sample) begin
      if (!i_out) begin
        run <= 2'h0;
      end else if (run != FQ_DEPTH) begin
        run <= run + 2'h1;
      end
    end
  end

  // Third reading in a row trips when queued, any one otherwise
  assign o_trip = i_sample & i_out & (!i_qen | (run >= FQ_DEPTH - 2'h1));

  a_queue_three: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_qen && i_sample && run < 2'h2) |-> !o_trip)
    else $error("queue tripped before third reading");
  a_queue_reset: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_sample && !i_out) |=> run == 2'h0)
    else $error("queue count kept after in-limit reading");
endmodule
`default_nettype wire

// ==== rdm_host.sv ====
// Serial bus host model facing the monitor's serial pins.
// Assumes a pull-up on the data line; the clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module rdm_host (
  output logic o_scl, // Serial clock
  output logic o_sda, // Data drive, 1 = released
  input wire logic i_sda // Wired data level
);
  localparam real Q = 31.25; // Quarter of the 125 ns bit
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // ----------------------------------------------------------
  // Framing
  // ----------------------------------------------------------
  // Start or repeated start from any bus phase
  task automatic bus_start();
    #Q o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b0;
  endtask
  // Stop, clock left standing high
  task automatic bus_stop();
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b1;
    #Q;
  endtask
  // Eight bits, first bit most significant; data moves mid-low phase
  task automatic put_bits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #Q o_sda = b[i];
      #Q o_scl = 1'b1;
      #(2*Q) o_scl = 1'b0;
    end
  endtask
  // Ninth clock with data released; low level means acknowledged
  task automatic get_ack(output logic k);
    #Q o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q k = !i_sda;
    #Q o_scl = 1'b0;
  endtask
  // Whole byte plus its acknowledge
  task automatic send(input logic [7:0] b, output logic k);
    put_bits(b);
    get_ack(k);
  endtask
  // Read byte, then acknowledge or refuse it
  task automatic get_byte(input logic nack, output logic [7:0] b);
    o_sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #(2*Q) o_scl = 1'b1;
      #Q b[i] = i_sda;
      #Q o_scl = 1'b0;
    end
    #Q o_sda = nack;
    #Q o_scl = 1'b1;
    #(2*Q) o_scl = 1'b0;
  endtask
  // Hold the clock low to force every slave back to idle
  task automatic hold_low(input int ns);
    o_scl = 1'b0;
    #(ns);
  endtask
endmodule
`default_nettype wire

// ==== rdm_monitor.sv ====
// Remote diode monitor: serial slave, registers, filter, limits.
// Assumes pins arrive asynchronously; converter runs on this clock.
`timescale 1ns/1ps
`default_nettype none
module rdm_monitor import rdm_pkg::*; #(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC // Bus low timeout
) (
  input wire logic i_ref_clk,      // System clock 100 MHz
  input wire logic i_sys_rst,      // Async reset, high
  input wire logic i_scl,          // Serial clock pin
  input wire logic i_sda,          // Serial data pin in
  output logic o_sda_out,          // Serial data out level
  output logic o_sda_oe,           // Serial data pull low
  output logic o_alert_out,        // Alarm pin out level
  output logic o_alert_oe,         // Alarm pin pull low
  input wire rdm_conv_t i_conv,    // Converter result
  input wire logic i_conv_done,    // Conversion end pulse
  output logic o_conv_run          // Converter may run
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [1:0] scl_sy, sda_sy; // Pin synchronisers
  logic scl_d, sda_d;         // Previous synced levels
  logic scl, sda;             // Synced levels
  logic start_det, stop_det, scl_rise, scl_fall;
  logic [31:0] to_cnt;        // Bus low time
  logic to_hit;               // Timeout reached
  rdm_bus_state_t state;
  logic [7:0] sh;             // Byte shifter
  logic [3:0] bits;           // Bit counter
  logic rnw;                  // Read transfer
  logic [7:0] ptr;            // Command pointer
  logic [7:0] canon;          // Pointer after mirror fold
  logic wr_stb;               // Data byte write pulse
  logic rd_clr;               // Status read pulse
  logic [7:0] rd_byte;        // Read mux
  logic [7:0] cfg, filt, hi_lim, lo_lim, crit, status;
  logic pend;                 // One-shot pending
  logic [10:0] rdg;           // Filtered reading
  logic [10:0] next_rdg;
  logic signed [11:0] diff;
  logic [7:0] nhb;            // New high byte
  logic [2:0] outv, trip;     // High, low, crit
  logic [7:0] next_status;
  logic alert_q;

  // ------------------------------------------------------------
  // Pin synchronisers and bus events
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], i_scl};
      sda_sy <= {sda_sy[0], i_sda};
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
    end
  end
  assign scl = scl_sy[1];
  assign sda = sda_sy[1];
  assign start_det = scl & scl_d & sda_d & !sda;
  assign stop_det = scl & scl_d & !sda_d & sda;
  assign scl_rise = scl & !scl_d;
  assign scl_fall = !scl & scl_d;

  // Counts while either line is low
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      to_cnt <= 32'h0;
    end else if ((scl & sda) | to_hit) begin
      to_cnt <= 32'h0;
    end else begin
      to_cnt <= to_cnt + 32'h1;
    end
  end
  assign to_hit = (to_cnt == 32'(TIMEOUT_CYCLES - 1));

  // ------------------------------------------------------------
  // Serial slave state machine
  // ------------------------------------------------------------
  assign canon = rdm_canon(ptr);
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      sh <= 8'h00;
      bits <= 4'h0;
      rnw <= 1'b0;
      ptr <= 8'h00;
      o_sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
      if (to_hit) begin
        state <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (start_det) begin
        state <= ST_ADDR;
        bits <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda};
              bits <= bits + 4'h1;
            end else if (scl_fall && bits == 4'h8) begin
              bits <= 4'h0;
              if (state == ST_ADDR) begin
                if (sh[7:1] == SLAVE_ADDR) begin
                  rnw <= sh[0];
                  o_sda_oe <= 1'b1;
                  state <= ST_AACK;
                end else begin
                  state <= ST_WAIT;
                end
              end else if (state == ST_CMD) begin
                ptr <= sh;
                o_sda_oe <= 1'b1;
                state <= ST_CACK;
              end else begin
                wr_stb <= 1'b1;
                o_sda_oe <= 1'b1;
                state <= ST_DACK;
              end
            end
          end
          ST_AACK: if (scl_fall) begin
            if (rnw) begin
              // Present the first data bit as the ack ends
              sh <= rd_byte;
              o_sda_oe <= !rd_byte[7];
              rd_clr <= (canon == REG_STATUS);
              state <= ST_RDATA;
            end else begin
              o_sda_oe <= 1'b0;
              state <= ST_CMD;
            end
          end
          ST_CACK: if (scl_fall) begin
            o_sda_oe <= 1'b0;
            state <= ST_WDATA;
          end
          ST_DACK: if (scl_fall) begin
            o_sda_oe <= 1'b0;
            state <= ST_WAIT;
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bits <= bits + 4'h1;
            end else if (scl_fall) begin
              if (bits == 4'h8) begin
                bits <= 4'h0;
                o_sda_oe <= 1'b0;
                state <= ST_RACK;
              end else begin
                sh <= {sh[6:0], 1'b0};
                o_sda_oe <= !sh[6];
              end
            end
          end
          // Ack repeats the same register, nack ends the read
          ST_RACK: if (scl_rise) begin
            state <= sda ? ST_WAIT : ST_AACK;
          end
          default: begin
            // Idle or ignoring the rest of a transfer
          end
        endcase
      end
    end
  end
  assign o_sda_out = 1'b0;
  assign o_alert_out = 1'b0;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg <= CONFIG_RST;
      filt <= FILTER_RST;
      hi_lim <= HI_LIM_RST;
      lo_lim <= LO_LIM_RST;
      crit <= CRIT_RST;
      pend <= 1'b0;
    end else begin
      if (i_conv_done) begin
        pend <= 1'b0;
      end
      if (wr_stb) begin
        case (canon)
          REG_CONFIG: cfg <= sh & CFG_WMASK;
          REG_FILTER: filt <= sh & FLT_WMASK;
          REG_HI_LIM: hi_lim <= sh;
          REG_LO_LIM: lo_lim <= sh;
          REG_CRIT: crit <= sh;
          REG_ONE_SHOT: if (cfg[CFG_STBY]) pend <= 1'b1;
          default: begin
            // Read-only or unused: write ignored
          end
        endcase
      end
    end
  end
  assign o_conv_run = !cfg[CFG_STBY] | pend;

  // Read mux; one-shot and unused locations read zero
  always_comb begin
    case (canon)
      REG_RMT_HB: rd_byte = rdg[10:3];
      REG_RMT_LB: rd_byte = {rdg[2:0], 5'h00};
      REG_STATUS: rd_byte = status;
      REG_CONFIG: rd_byte = cfg;
      REG_FILTER: rd_byte = filt;
      REG_HI_LIM: rd_byte = hi_lim;
      REG_LO_LIM: rd_byte = lo_lim;
      REG_CRIT: rd_byte = crit;
      default: rd_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Filter, fault forcing and limit comparison
  // ------------------------------------------------------------
  always_comb begin
    diff = {i_conv.temp[10], i_conv.temp} - {rdg[10], rdg};
    case (filt[FLT_HI:FLT_LO])
      2'h0: next_rdg = i_conv.temp;
      2'h3: next_rdg = rdg + 11'(diff >>> 2);
      default: next_rdg = rdg + 11'(diff >>> 1);
    endcase
    if (i_conv.diode_open) begin
      next_rdg = {FORCE_OPEN_HB, 3'h0};
    end else if (i_conv.diode_short) begin
      next_rdg = {FORCE_SHORT_HB, 3'h0};
    end
  end
  assign nhb = next_rdg[10:3];
  assign outv[0] = $signed(nhb) > $signed(hi_lim);
  assign outv[1] = $signed(lo_lim) > $signed(nhb);
  assign outv[2] = $signed(nhb) > $signed(crit);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdg <= 11'h000;
    end else if (i_conv_done) begin
      rdg <= next_rdg;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_queue
    rdm_fault_queue u_queue (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_sample(i_conv_done),
      .i_out(outv[g]),
      .i_qen(cfg[CFG_FQ]),
      .o_trip(trip[g])
    );
  end

  // ------------------------------------------------------------
  // Status and alarm
  // ------------------------------------------------------------
  always_comb begin
    next_status = rd_clr ? 8'h00 : status;
    next_status[ST_RHIGH] = next_status[ST_RHIGH] | trip[0];
    next_status[ST_RLOW] = next_status[ST_RLOW] | trip[1];
    next_status[ST_RCRIT] = next_status[ST_RCRIT] | trip[2];
    next_status[ST_FAULT] = next_status[ST_FAULT] | (i_conv_done & i_conv.diode_open);
  end
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status <= 8'h00;
      alert_q <= 1'b0;
    end else begin
      status <= next_status;
      alert_q <= (|(status & ALARM_BITS)) & !cfg[CFG_MASK];
    end
  end
  assign o_alert_oe = alert_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_open_conv;
    i_conv_done && i_conv.diode_open;
  endsequence
  sequence s_short_conv;
    i_conv_done && i_conv.diode_short && !i_conv.diode_open;
  endsequence

  a_open_forced: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_open_conv |=> rdg == {FORCE_OPEN_HB, 3'h0} && status[ST_FAULT])
    else $error("open diode reading not forced");
  a_fault_quiet: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (status & ALARM_BITS) == 8'h00 |=> !o_alert_oe)
    else $error("alarm without limit status");
  a_open_alarm: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (s_open_conv and (!cfg[CFG_MASK] && !cfg[CFG_FQ]
      && ($signed(crit) < $signed(FORCE_OPEN_HB) || $signed(hi_lim) < $signed(FORCE_OPEN_HB))))
    ##1 !cfg[CFG_MASK] |=> o_alert_oe)
    else $error("open diode did not alarm");
  a_short_forced: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_short_conv |=> rdg[10:3] == FORCE_SHORT_HB
      && status[ST_FAULT] == $past(status[ST_FAULT] && !rd_clr))
    else $error("ground short reading wrong");
  a_short_alarm: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (s_short_conv and (!cfg[CFG_MASK] && !cfg[CFG_FQ]
      && $signed(lo_lim) > $signed(FORCE_SHORT_HB))) ##1 !cfg[CFG_MASK] |=> o_alert_oe)
    else $error("ground short did not alarm");
  a_single_byte: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state == ST_WAIT |=> !wr_stb)
    else $error("extra data byte written");
  a_oneshot_go: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr_stb && canon == REG_ONE_SHOT && cfg[CFG_STBY]) |=> o_conv_run [*2])
    else $error("one-shot did not start conversion");
  a_oneshot_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state == ST_AACK && scl_fall && rnw && canon == REG_ONE_SHOT && !to_hit
      && !start_det && !stop_det) |=> sh == 8'h00 && o_sda_oe) // Zero bit means line pulled low
    else $error("one-shot read not zero");
  a_timeout_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    to_hit |=> state == ST_IDLE && !o_sda_oe)
    else $error("bus timeout did not reset slave");
  a_start_addr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (start_det && !to_hit) |=> state == ST_ADDR && bits == 4'h0)
    else $error("start not accepted");
  a_status_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (status[ST_RHIGH] && !rd_clr) |=> status[ST_RHIGH])
    else $error("status cleared without read");
endmodule
`default_nettype wire

// ==== rdm_pkg.sv ====
// Constants, types and helpers for the remote diode monitor block.
// Assumes one 100 MHz clock and an analog front end on the same clock.
`default_nettype none
package rdm_pkg;
  // ------------------------------------------------------------
  // Bus address and register offsets
  // ------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h4C;
  localparam logic [7:0] REG_RMT_HB = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h03;
  localparam logic [7:0] REG_HI_LIM = 8'h07;
  localparam logic [7:0] REG_LO_LIM = 8'h08;
  localparam logic [7:0] REG_CONFIG_M = 8'h09;
  localparam logic [7:0] REG_HI_LIM_M = 8'h0D;
  localparam logic [7:0] REG_LO_LIM_M = 8'h0E;
  localparam logic [7:0] REG_ONE_SHOT = 8'h0F;
  localparam logic [7:0] REG_RMT_LB = 8'h10;
  localparam logic [7:0] REG_CRIT = 8'h19;
  localparam logic [7:0] REG_FILTER = 8'h50;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ST_RHIGH = 4;
  localparam int ST_RLOW = 3;
  localparam int ST_FAULT = 2;
  localparam int ST_RCRIT = 1;
  localparam int CFG_MASK = 7;
  localparam int CFG_STBY = 6;
  localparam int CFG_FQ = 0;
  localparam int FLT_HI = 2;
  localparam int FLT_LO = 1;
  localparam logic [7:0] ALARM_BITS = 8'h1A;
  localparam logic [7:0] CFG_WMASK = 8'hE7;
  localparam logic [7:0] FLT_WMASK = 8'h06;
  // ------------------------------------------------------------
  // Reset and forced values
  // ------------------------------------------------------------
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] FILTER_RST = 8'h00;
  localparam logic [7:0] HI_LIM_RST = 8'h46;
  localparam logic [7:0] LO_LIM_RST = 8'h00;
  localparam logic [7:0] CRIT_RST = 8'h6E;
  localparam logic [7:0] FORCE_OPEN_HB = 8'h7F;
  localparam logic [7:0] FORCE_SHORT_HB = 8'h80;
  localparam logic [1:0] FQ_DEPTH = 2'h3;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int BUS_TIMEOUT_US = 35000;
  localparam int TIMEOUT_CYC = BUS_TIMEOUT_US * CLK_MHZ;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic diode_open;  // Anode open or tied to supply
    logic diode_short; // Anode tied to ground or cathode
    logic [10:0] temp; // Raw reading, 0.125 degree steps
  } rdm_conv_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK,
    ST_WDATA, ST_DACK, ST_RDATA, ST_RACK, ST_WAIT
  } rdm_bus_state_t;
  // Folds mirror addresses onto their primary register
  function automatic logic [7:0] rdm_canon(input logic [7:0] a);
    case (a)
      REG_CONFIG_M: return REG_CONFIG;
      REG_HI_LIM_M: return REG_HI_LIM;
      REG_LO_LIM_M: return REG_LO_LIM;
      default: return a;
    endcase
  endfunction
endpackage
`default_nettype wire

// ==== test_rdm_monitor.sv ====
// Self-checking bench for the remote diode monitor.
// Assumes rdm_host on the serial pins and a pulsed converter model.
`timescale 1ns/1ps
`default_nettype none
module test_rdm_monitor
  import rdm_pkg::*;
;
  localparam int TO = 200; // Shortened bus timeout
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic scl, host_sda, sda_out, sda_oe, alert_out, alert_oe, run;
  rdm_conv_t conv = '0;
  logic done = 1'b0;
  logic k;
  logic [7:0] d;
  wire logic sda_w = host_sda & (sda_oe ? sda_out : 1'b1); // Wired bus
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  rdm_monitor #(.TIMEOUT_CYCLES(TO)) dut (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda_w), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_alert_out(alert_out), .o_alert_oe(alert_oe),
    .i_conv(conv), .i_conv_done(done), .o_conv_run(run));
  rdm_host host (.o_scl(scl), .o_sda(host_sda), .i_sda(sda_w));
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.bus_start();
    host.send({SLAVE_ADDR, 1'b0}, k);
    host.send(a, k);
    host.send(v, k);
    host.bus_stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    host.bus_start();
    host.send({SLAVE_ADDR, 1'b0}, k);
    host.send(a, k);
    host.bus_start();
    host.send({SLAVE_ADDR, 1'b1}, k);
    host.get_byte(1'b1, v);
    host.bus_stop();
  endtask
  // One conversion result, pulsed just after an edge
  task automatic cv(input logic o, input logic s, input logic [10:0] t);
    @(posedge i_ref_clk);
    #1 conv = '{diode_open: o, diode_short: s, temp: t};
    done = 1'b1;
    @(posedge i_ref_clk);
    #1 done = 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_mirror();
    rd(REG_CONFIG, d); chk("config reset", CONFIG_RST, d);
    wr(REG_HI_LIM_M, 8'h7F);
    rd(REG_HI_LIM, d); chk("high via mirror", 8'h7F, d);
    wr(REG_CRIT, 8'h7F);
    host.bus_start();
    host.send({SLAVE_ADDR, 1'b0}, k);
    host.send(REG_LO_LIM, k);
    host.send(8'h12, k); chk("data ack", 8'h01, {7'h0, k});
    host.send(8'h34, k); chk("extra ack", 8'h00, {7'h0, k});
    host.bus_stop();
    rd(REG_LO_LIM_M, d); chk("low via mirror", 8'h12, d);
    $display("test mirror done");
  endtask
  task automatic t_diode();
    cv(1'b1, 1'b0, 11'h0); chk("alarm fault only", 8'h00, {7'h0, alert_oe});
    rd(REG_STATUS, d); chk("status open", 8'h04, d);
    rd(REG_RMT_HB, d); chk("open high", FORCE_OPEN_HB, d);
    rd(REG_RMT_LB, d); chk("open low", 8'h00, d);
    rd(REG_STATUS, d); chk("status cleared", 8'h00, d);
    wr(REG_CRIT, CRIT_RST);
    cv(1'b1, 1'b0, 11'h0); chk("alarm open", 8'h01, {7'h0, alert_oe});
    chk("alarm pin level", 8'h00, {7'h0, alert_out});
    rd(REG_STATUS, d); chk("status crit", 8'h06, d);
    wr(REG_CONFIG, 8'h80);
    cv(1'b0, 1'b1, 11'h0); chk("alarm masked", 8'h00, {7'h0, alert_oe});
    rd(REG_RMT_HB, d); chk("short high", FORCE_SHORT_HB, d);
    rd(REG_STATUS, d); chk("status short", 8'h08, d);
    wr(REG_CONFIG, 8'h00);
    cv(1'b0, 1'b1, 11'h0); chk("alarm short", 8'h01, {7'h0, alert_oe});
    rd(REG_STATUS, d);
    $display("test diode done");
  endtask
  task automatic t_filter();
    logic [7:0] sel [3] = '{8'h06, 8'h02, 8'h04};
    logic [10:0] x [3] = '{11'h0E9, 11'h0F1, 11'h0F1};
    logic [7:0] hb [3] = '{8'h1A, 8'h1C, 8'h1D};
    cv(1'b0, 1'b0, 11'h0C9);
    rd(REG_RMT_HB, d); chk("raw high", 8'h19, d);
    rd(REG_RMT_LB, d); chk("raw low", 8'h20, d);
    for (int i = 0; i < 3; i++) begin
      wr(REG_FILTER, sel[i]);
      cv(1'b0, 1'b0, x[i]);
      rd(REG_RMT_HB, d); chk("filtered high", hb[i], d);
      rd(REG_RMT_LB, d); chk("filtered low", 8'h20, d);
    end
    wr(REG_FILTER, 8'h00);
    $display("test filter done");
  endtask
  task automatic t_queue();
    wr(REG_HI_LIM, 8'h46);
    wr(REG_CONFIG, 8'h01);
    repeat (2) cv(1'b0, 1'b0, 11'h280);
    chk("queue two", 8'h00, {7'h0, alert_oe});
    cv(1'b0, 1'b0, 11'h280); chk("queue three", 8'h01, {7'h0, alert_oe});
    rd(REG_STATUS, d); chk("queue status", 8'h10, d);
    cv(1'b0, 1'b0, 11'h0C8);
    repeat (2) cv(1'b0, 1'b0, 11'h280);
    chk("queue restart", 8'h00, {7'h0, alert_oe});
    cv(1'b0, 1'b0, 11'h280); chk("queue retrip", 8'h01, {7'h0, alert_oe});
    rd(REG_STATUS, d);
    wr(REG_CONFIG, 8'h00);
    $display("test queue done");
  endtask
  task automatic t_oneshot();
    wr(REG_CONFIG_M, 8'h40); chk("standby run", 8'h00, {7'h0, run});
    wr(REG_ONE_SHOT, 8'hA5); chk("one-shot run", 8'h01, {7'h0, run});
    cv(1'b0, 1'b0, 11'h0C8); chk("back to standby", 8'h00, {7'h0, run});
    rd(REG_ONE_SHOT, d); chk("one-shot read", 8'h00, d);
    wr(REG_CONFIG, 8'h00);
    $display("test oneshot done");
  endtask
  task automatic t_bus();
    host.bus_start();
    host.send(8'h9A, k); chk("foreign addr ack", 8'h00, {7'h0, k});
    host.bus_stop();
    host.bus_start();
    host.put_bits({SLAVE_ADDR, 1'b0});
    #100 chk("ack held", 8'h01, {7'h0, sda_oe});
    host.hold_low(TO * 10 + 300);
    chk("timeout release", 8'h00, {7'h0, sda_oe});
    host.bus_start();
    host.send({SLAVE_ADDR, 1'b0}, k);
    host.bus_start();
    host.send({SLAVE_ADDR, 1'b0}, k);
    host.send(REG_LO_LIM, k);
    host.send(8'h21, k);
    host.bus_stop();
    host.bus_start();
    host.send({SLAVE_ADDR, 1'b0}, k);
    host.send(REG_LO_LIM, k);
    host.bus_start();
    host.send({SLAVE_ADDR, 1'b1}, k);
    host.get_byte(1'b0, d); chk("after restart", 8'h21, d);
    host.get_byte(1'b1, d); chk("acked reread", 8'h21, d);
    host.bus_stop();
    $display("test bus done");
  endtask
  // ----------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      $display("[FAIL] watchdog expected end seen hang");
      finish_test();
    end
  end
  initial begin
    repeat (3) @(posedge i_ref_clk);
    #1 i_sys_rst = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    t_mirror();
    t_diode();
    t_filter();
    t_queue();
    t_oneshot();
    t_bus();
    finish_test();
  end
endmodule
`default_nettype wire
